// File: logic/dcf_regs.svh
// constants for the dual-clock fifo: sizes, offsets, fields, reset values
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH
`define DCF_WIDTH       18
`define DCF_DEPTH       2048
`define DCF_OFF_BITS    10
`define DCF_DEF_OFFSET  10'h100
`define DCF_REG_CTRL    32'h0000_0000
`define DCF_REG_STAT    32'h0000_0004
`define DCF_REG_COUNT   32'h0000_0008
`define DCF_REG_OFFSET  32'h0000_000C
`define DCF_CTRL_WINH   0
`define DCF_CTRL_RESET  1'h0
`define DCF_HSIZE_WORD  3'h2
`endif

// File: logic/dcf_pkg.sv
// types shared by the dual-clock fifo files
`default_nettype none
package dcf_pkg;
    // write-side start-up sequence after reset, gray coded
    typedef enum logic [1:0] {
        DCF_WS_RESET = 2'h0,
        DCF_WS_ONE   = 2'h1,
        DCF_WS_RUN   = 2'h3
    } dcf_wstart_t;
endpackage : dcf_pkg
`default_nettype wire

// File: logic/dcf_mem.sv
// storage array of the fifo: clocked write, direct read
`default_nettype none
module dcf_mem #(
    parameter int W  = 18,
    parameter int AW = 11
) (
    input  wire logic          clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] store [0:(1<<AW)-1];

    // no reset: contents are data, never control
    always_ff @(posedge clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    assign rd_data = store[rd_addr];
endmodule : dcf_mem
`default_nettype wire

// File: logic/dcf_ahb.sv
// ahb-lite register slave of the fifo, one wait state on every transfer
`default_nettype none
`include "dcf_regs.svh"
module dcf_ahb (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             write_inhibit,
    input  wire logic [31:0] stat_word,
    input  wire logic [31:0] count_word,
    input  wire logic [31:0] offset_word
);
    logic        pend;
    logic        p_write;
    logic        p_word;
    logic [31:0] p_addr;
    logic        next_pend;
    logic        next_p_write;
    logic        next_p_word;
    logic [31:0] next_p_addr;
    logic        next_hreadyout;
    logic [31:0] next_hrdata;
    logic        next_winh;
    logic        addr_phase;

    assign addr_phase = hsel && htrans[1] && hready;

    always_comb begin
        next_pend      = addr_phase;
        next_p_write   = addr_phase ? hwrite : p_write;
        next_p_word    = addr_phase ? (hsize == `DCF_HSIZE_WORD) : p_word;
        next_p_addr    = addr_phase ? haddr : p_addr;
        next_hreadyout = !addr_phase;
        next_hrdata    = hrdata;
        next_winh      = write_inhibit;
        if (pend && p_write) begin
            // only whole-word writes land; others are dropped quietly
            if (p_word && p_addr == `DCF_REG_CTRL) begin
                next_winh = hwdata[`DCF_CTRL_WINH];
            end
        end else if (pend) begin
            if (p_addr == `DCF_REG_CTRL) begin
                next_hrdata = {31'h0, write_inhibit};
            end else if (p_addr == `DCF_REG_STAT) begin
                next_hrdata = stat_word;
            end else if (p_addr == `DCF_REG_COUNT) begin
                next_hrdata = count_word;
            end else if (p_addr == `DCF_REG_OFFSET) begin
                next_hrdata = offset_word;
            end else begin
                next_hrdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend          <= 1'b0;
            p_write       <= 1'b0;
            p_word        <= 1'b0;
            p_addr        <= 32'h0000_0000;
            hreadyout     <= 1'b1;
            hrdata        <= 32'h0000_0000;
            hresp         <= 1'b0;
            write_inhibit <= `DCF_CTRL_RESET;
        end else begin
            pend          <= next_pend;
            p_write       <= next_p_write;
            p_word        <= next_p_word;
            p_addr        <= next_p_addr;
            hreadyout     <= next_hreadyout;
            hrdata        <= next_hrdata;
            hresp         <= 1'b0;
            write_inhibit <= next_winh;
        end
    end
endmodule : dcf_ahb
`default_nettype wire

// File: logic/dcf_top.sv
// dual-clock fifo, read side and status flags, with write port and registers
//
// Summary of operation
// - 18-bit input words; data bits 9..0 latched on strobe falling edge, loaded as offset only if strobe low at reset release.
// - half-full high at 1024 or more words, low below half depth.
// - input-ready high while not full, low while full.
// - input-ready goes low while reset is held.
// - input-ready rises on the second write-clock edge after reset release.
// - after full, input-ready rises on second write-clock edge after a read.
// - data outputs float from the sys_clk edge after output enable goes low.
// - output-ready high while a word is held, low while empty.
// - output-ready goes low while reset is held.
// - output-ready rises on third read-clock edge after first write.
// - output-ready drops at the read that takes the last word.
// - first word appears at third read-clock edge, ignoring read enables.
// - later words unload only with both enables, output enable, output-ready high.
// - reads and output-ready are timed by the free-running read clock.
// - the store holds 2048 words of 18 bits.
// - a word is written only with input-ready and both write enables high.
// - boundary flag high at count <= offset or >= 2048-offset; default 256.
// - reset clears pointers, lowers ready and half flags, raises boundary flag.
`default_nettype none
`include "dcf_regs.svh"
module dcf_top #(
    parameter int WIDTH = `DCF_WIDTH,
    parameter int DEPTH = `DCF_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             write_clock,
    input  wire logic             read_clock,
    input  wire logic [WIDTH-1:0] write_data_in,
    input  wire logic             write_enable_a,
    input  wire logic             write_enable_b,
    input  wire logic             offset_capture_strobe_n,
    input  wire logic             read_enable_a,
    input  wire logic             read_enable_b,
    input  wire logic             output_enable,
    output logic      [WIDTH-1:0] read_data_out,
    output logic                  read_data_oe,
    output logic                  input_ready_flag,
    output logic                  output_ready_flag,
    output logic                  half_full_flag,
    output logic                  almost_boundary_flag,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp
);
    import dcf_pkg::*;

    localparam int             AW      = $clog2(DEPTH);
    localparam int             OB      = `DCF_OFF_BITS;
    localparam logic [AW:0]    DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0]    HALF_C  = (AW+1)'(DEPTH / 2);

    if (DEPTH != (1 << AW) || AW <= OB || WIDTH < OB || AW > 30) begin : g_check
        $error("dcf_top: depth must be a power of two above 1024, width 10 or more");
    end

    function automatic logic [AW:0] fill(input logic [AW:0] a, input logic [AW:0] b);
        return a - b;
    endfunction : fill

    function automatic logic [AW:0] widen(input logic [OB-1:0] v);
        return {{(AW+1-OB){1'b0}}, v};
    endfunction : widen

    ////////////////////////////////////////////////////////////////////////////
    // clock edge detection; both clocks are sampled inputs of sys_clk

    logic wclk_q;
    logic rclk_q;
    logic w_rise;
    logic r_rise;

    assign w_rise = write_clock && !wclk_q;
    assign r_rise = read_clock && !rclk_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wclk_q <= 1'b1;
            rclk_q <= 1'b1;
        end else begin
            wclk_q <= write_clock;
            rclk_q <= read_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // offset capture; kept through reset so a held-low strobe reuses it

    logic          strobe_q;
    logic [OB-1:0] x_store;

    always_ff @(posedge sys_clk) begin
        strobe_q <= offset_capture_strobe_n;
        if (strobe_q && !offset_capture_strobe_n) begin
            x_store <= write_data_in[OB-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write side

    logic          write_inhibit;
    logic [AW:0]   wptr;
    logic [AW:0]   rptr;
    logic [AW:0]   rp_pipe;
    dcf_wstart_t   wstart;
    logic [AW:0]   next_wptr;
    logic [AW:0]   next_rp_pipe;
    dcf_wstart_t   next_wstart;
    logic          next_irdy;
    logic          wr_go;

    // write inhibit from software blocks writes without touching flags
    assign wr_go = w_rise && input_ready_flag && write_enable_a && write_enable_b
                   && !write_inhibit;

    always_comb begin
        next_wptr    = wptr + {{AW{1'b0}}, wr_go};
        next_rp_pipe = w_rise ? rptr : rp_pipe;
        next_wstart  = wstart;
        next_irdy    = input_ready_flag;
        if (w_rise) begin
            case (wstart)
                DCF_WS_RESET: begin
                    next_wstart = DCF_WS_ONE;
                end
                default: begin
                    next_wstart = DCF_WS_RUN;
                end
            endcase
            // read seen one edge ago in rp_pipe gives the second-edge rise
            next_irdy = (wstart != DCF_WS_RESET)
                        && (fill(next_wptr, rp_pipe) != DEPTH_C);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr             <= '0;
            rp_pipe          <= '0;
            wstart           <= DCF_WS_RESET;
            input_ready_flag <= 1'b0;
        end else begin
            wptr             <= next_wptr;
            rp_pipe          <= next_rp_pipe;
            wstart           <= next_wstart;
            input_ready_flag <= next_irdy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage

    logic [WIDTH-1:0] rd_data;

    dcf_mem #(
        .W  (WIDTH),
        .AW (AW)
    ) u_mem (
        .clk     (sys_clk),
        .wr_en   (wr_go),
        .wr_addr (wptr[AW-1:0]),
        .wr_data (write_data_in),
        .rd_addr (rptr[AW-1:0]),
        .rd_data (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read side

    logic [AW:0]      wp1;
    logic [AW:0]      wp2;
    logic [AW:0]      next_wp1;
    logic [AW:0]      next_wp2;
    logic [AW:0]      next_rptr;
    logic             next_orf;
    logic [WIDTH-1:0] next_dout;
    logic             avail;
    logic             rd_go;

    assign avail = rptr != wp2;
    assign rd_go = r_rise && output_ready_flag && read_enable_a && read_enable_b
                   && output_enable;

    always_comb begin
        next_wp1  = r_rise ? wptr : wp1;
        next_wp2  = r_rise ? wp1 : wp2;
        next_rptr = rptr;
        next_orf  = output_ready_flag;
        next_dout = read_data_out;
        if (r_rise && !output_ready_flag && avail) begin
            next_dout = rd_data;
            next_rptr = rptr + {{AW{1'b0}}, 1'b1};
            next_orf  = 1'b1;
        end else if (rd_go && avail) begin
            next_dout = rd_data;
            next_rptr = rptr + {{AW{1'b0}}, 1'b1};
        end else if (rd_go) begin
            next_orf = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp1               <= '0;
            wp2               <= '0;
            rptr              <= '0;
            output_ready_flag <= 1'b0;
            read_data_out     <= '0;
        end else begin
            wp1               <= next_wp1;
            wp2               <= next_wp2;
            rptr              <= next_rptr;
            output_ready_flag <= next_orf;
            read_data_out     <= next_dout;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level flags; count excludes the word parked on the outputs

    logic [AW:0]   count_q;
    logic [OB-1:0] offset;
    logic          cfg_done;
    logic [AW:0]   next_count;
    logic [OB-1:0] next_offset;
    logic          next_half;
    logic          next_abf;

    always_comb begin
        next_count  = fill(wptr, rp_pipe);
        next_offset = offset;
        if (!cfg_done) begin
            // taken once, just after reset release
            next_offset = offset_capture_strobe_n ? `DCF_DEF_OFFSET : x_store;
        end
        next_half = count_q >= HALF_C;
        next_abf = (count_q <= widen(offset))
                   || (count_q >= DEPTH_C - widen(offset));
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q              <= '0;
            offset               <= `DCF_DEF_OFFSET;
            cfg_done             <= 1'b0;
            half_full_flag       <= 1'b0;
            almost_boundary_flag <= 1'b1;
            read_data_oe         <= 1'b0;
        end else begin
            count_q              <= next_count;
            offset               <= next_offset;
            cfg_done             <= 1'b1;
            half_full_flag       <= next_half;
            almost_boundary_flag <= next_abf;
            read_data_oe         <= output_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register slave

    dcf_ahb u_ahb (
        .clk           (sys_clk),
        .rst_b         (rst_b),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hready),
        .hrdata        (hrdata),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .write_inhibit (write_inhibit),
        .stat_word     ({28'h0, almost_boundary_flag, half_full_flag,
                         output_ready_flag, input_ready_flag}),
        .count_word    ({{(31-AW){1'b0}}, count_q}),
        .offset_word   ({{(32-OB){1'b0}}, offset})
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_irdy_not_full: assert property (
        input_ready_flag |-> fill(wptr, rp_pipe) != DEPTH_C)
        else $error("input ready high while full");

    chk_write_gate: assert property (
        (wptr != $past(wptr)) |-> $past(w_rise && input_ready_flag && write_enable_a
                                        && write_enable_b))
        else $error("write without ready and both enables");

    chk_irdy_startup: assert property (
        (wstart == DCF_WS_RESET) |-> !input_ready_flag)
        else $error("input ready before second write edge");

    chk_read_gate: assert property (
        (rptr != $past(rptr)) && $past(output_ready_flag)
        |-> $past(r_rise && read_enable_a && read_enable_b && output_enable))
        else $error("unload without both enables and output enable");

    chk_or_last_word: assert property (
        rd_go && !avail |=> !output_ready_flag)
        else $error("output ready kept after last word");

    chk_first_word: assert property (
        r_rise && !output_ready_flag && avail
        |=> output_ready_flag && read_data_out == $past(rd_data))
        else $error("first word not presented");

    chk_oe_float: assert property (
        !output_enable |=> !read_data_oe)
        else $error("outputs driven with output enable low");

    chk_reset_flags: assert property (
        !cfg_done |-> almost_boundary_flag && !half_full_flag && !input_ready_flag
                      && !output_ready_flag && wptr == '0 && rptr == '0)
        else $error("flags wrong after reset");

    chk_half_level: assert property (
        cfg_done && (count_q >= HALF_C) |=> half_full_flag)
        else $error("half full missing at half depth");

    cov_fill_up: cover property (input_ready_flag ##1 !input_ready_flag);
    cov_first_out: cover property (!output_ready_flag ##1 output_ready_flag);
    cov_half: cover property (!half_full_flag ##1 half_full_flag);
    cov_drain: cover property (rd_go && !avail);
endmodule : dcf_top
`default_nettype wire

// File: tb/dcf_far_end.sv
// far-end model: free-running write and read clocks, edge ticks, resolved output bus
`default_nettype none
module dcf_far_end (
    input  wire logic        sys_clk,
    input  wire logic [17:0] read_data_out,
    input  wire logic        read_data_oe,
    output logic             write_clock,
    output logic             read_clock,
    output logic             wr_tick,
    output logic             rd_tick,
    output logic      [17:0] q_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt     = 2'h0;
    logic       wr_seen = 1'b0;
    logic       rd_seen = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // both clocks run free at a quarter of sys_clk; rising edges kept apart so
    // a write tick and a read tick never land on the same sys_clk edge
    always @(posedge sys_clk) begin
        cnt         <= cnt + 2'h1;
        write_clock <= cnt[1];
        read_clock  <= cnt[1] ~^ cnt[0];
        wr_seen     <= write_clock;
        rd_seen     <= read_clock;
    end
    // tick marks the sys_clk edge at which the block sees the rising edge
    assign wr_tick = write_clock & ~wr_seen;
    assign rd_tick = read_clock & ~rd_seen;
    // no pull on the data lines: a released bus floats
    assign q_bus = read_data_oe ? read_data_out : {18{1'bz}};
endmodule : dcf_far_end
`default_nettype wire

// File: tb/test_dcf_top.sv
// self-checking bench for the dual-clock fifo read side and flags
`default_nettype none
`include "dcf_regs.svh"
module test_dcf_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_b, write_clock, read_clock, wr_tick, rd_tick;
    logic [17:0] write_data_in, read_data_out, q_bus;
    logic        write_enable_a, write_enable_b, offset_capture_strobe_n;
    logic        read_enable_a, read_enable_b, output_enable, read_data_oe;
    logic        input_ready_flag, output_ready_flag, half_full_flag;
    logic        almost_boundary_flag, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_fail = 0, checks_done = 0, wr_idx = 0, rd_idx = 0;

    dcf_top u_dcf_top (.sys_clk(sys_clk), .rst_b(rst_b), .write_clock(write_clock),
        .read_clock(read_clock), .write_data_in(write_data_in),
        .write_enable_a(write_enable_a), .write_enable_b(write_enable_b),
        .offset_capture_strobe_n(offset_capture_strobe_n), .read_enable_a(read_enable_a),
        .read_enable_b(read_enable_b), .output_enable(output_enable),
        .read_data_out(read_data_out), .read_data_oe(read_data_oe),
        .input_ready_flag(input_ready_flag), .output_ready_flag(output_ready_flag),
        .half_full_flag(half_full_flag), .almost_boundary_flag(almost_boundary_flag),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));
    dcf_far_end u_dcf_far_end (.sys_clk(sys_clk), .read_data_out(read_data_out),
        .read_data_oe(read_data_oe), .write_clock(write_clock), .read_clock(read_clock),
        .wr_tick(wr_tick), .rd_tick(rd_tick), .q_bus(q_bus));

    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic hang;
        n_fail++;
        $display("BAD wait ran out of cycles");
        results();
    endtask : hang
    function automatic logic [17:0] word(input int i);
        return 18'(i) ^ 18'h2AAAA;
    endfunction : word
    // returns one edge after the n-th tick, so sampled outputs are settled
    task automatic ticks(input bit rd, input int n);
        int k, seen;
        seen = 0;
        for (k = 0; k < 16 * n && seen < n; k++) begin
            @(posedge sys_clk);
            if (rd ? rd_tick : wr_tick) seen++;
        end
        if (seen < n) hang();
        @(posedge sys_clk);
    endtask : ticks
    task automatic settle;
        ticks(1'b1, 4);
        ticks(1'b0, 2);
    endtask : settle
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= `DCF_HSIZE_WORD;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0; hwdata <= d;
        do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 100);
        rdv = hrdata;
        if (k >= 100) hang();
        chk("hresp", hresp, 32'h0000_0000);
    endtask : ahb
    task automatic wr_words(input int n);
        int k, got;
        got = 0;
        @(posedge sys_clk);
        write_enable_a <= 1'b1; write_enable_b <= 1'b1; write_data_in <= word(wr_idx);
        for (k = 0; k < 8 * n + 16 && got < n; k++) begin
            @(posedge sys_clk);
            if (wr_tick && input_ready_flag) begin
                got++;
                wr_idx++;
                write_data_in <= word(wr_idx);
            end
        end
        write_enable_a <= 1'b0; write_enable_b <= 1'b0;
        if (got < n) hang();
    endtask : wr_words
    task automatic rd_words(input int n);
        int k, got;
        got = 0;
        @(posedge sys_clk);
        read_enable_a <= 1'b1; read_enable_b <= 1'b1; output_enable <= 1'b1;
        for (k = 0; k < 8 * n + 16 && got < n; k++) begin
            @(posedge sys_clk);
            if (rd_tick && output_ready_flag) begin
                got++;
                @(posedge sys_clk);
                if (output_ready_flag) chk("read_data_out", read_data_out, word(rd_idx));
                if (output_ready_flag) rd_idx++;
            end
        end
        read_enable_a <= 1'b0; read_enable_b <= 1'b0;
        if (got < n) hang();
    endtask : rd_words
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        ticks(1'b0, 1);
        chk("input_ready_flag", input_ready_flag, 32'h0000_0000);
        ticks(1'b0, 1);
        chk("input_ready_flag", input_ready_flag, 32'h0000_0001);
        ahb(`DCF_REG_OFFSET, 1'b0, 32'h0000_0000);
        chk("offset", rdv, 32'h0000_0100);
        ahb(`DCF_REG_STAT, 1'b0, 32'h0000_0000);
        chk("stat", rdv, 32'h0000_0009);
        ahb(32'h0000_0010, 1'b0, 32'h0000_0000);
        chk("unmapped", rdv, 32'h0000_0000);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_first;
        wr_words(1);
        ticks(1'b1, 2);
        chk("output_ready_flag", output_ready_flag, 32'h0000_0000);
        ticks(1'b1, 1);
        chk("output_ready_flag", output_ready_flag, 32'h0000_0001);
        chk("read_data_out", read_data_out, word(0));
        rd_idx = 1;
        wr_words(1);
        ticks(1'b1, 4);
        chk("read_data_out", read_data_out, word(0));
        output_enable <= 1'b0; read_enable_a <= 1'b1; read_enable_b <= 1'b1;
        ticks(1'b1, 2);
        chk("q_bus", q_bus, {14'h0000, {18{1'bz}}});
        chk("read_data_out", read_data_out, word(0));
        rd_words(2);
        chk("output_ready_flag", output_ready_flag, 32'h0000_0000);
        $display("t_first done");
    endtask : t_first
    task automatic t_refuse;
        write_enable_a <= 1'b1;
        ticks(1'b0, 3);
        write_enable_a <= 1'b0; write_enable_b <= 1'b1;
        ticks(1'b0, 3);
        write_enable_b <= 1'b0;
        ahb(`DCF_REG_CTRL, 1'b1, 32'h0000_0001);
        write_enable_a <= 1'b1; write_enable_b <= 1'b1;
        ticks(1'b0, 3);
        write_enable_a <= 1'b0; write_enable_b <= 1'b0;
        ahb(`DCF_REG_CTRL, 1'b1, 32'h0000_0000);
        ticks(1'b1, 4);
        chk("output_ready_flag", output_ready_flag, 32'h0000_0000);
        ahb(`DCF_REG_COUNT, 1'b0, 32'h0000_0000);
        chk("count", rdv, 32'h0000_0000);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_fill;
        rd_idx = wr_idx + 1;
        wr_words(600);
        settle();
        chk("half_full_flag", half_full_flag, 32'h0000_0000);
        chk("almost_boundary_flag", almost_boundary_flag, 32'h0000_0000);
        wr_words(424);
        settle();
        chk("half_full_flag", half_full_flag, 32'h0000_0000);
        wr_words(1);
        settle();
        chk("half_full_flag", half_full_flag, 32'h0000_0001);
        wr_words(1024);
        settle();
        chk("input_ready_flag", input_ready_flag, 32'h0000_0000);
        chk("almost_boundary_flag", almost_boundary_flag, 32'h0000_0001);
        ahb(`DCF_REG_COUNT, 1'b0, 32'h0000_0000);
        chk("count", rdv, 32'h0000_0800);
        rd_words(1);
        ticks(1'b0, 1);
        chk("input_ready_flag", input_ready_flag, 32'h0000_0000);
        ticks(1'b0, 1);
        chk("input_ready_flag", input_ready_flag, 32'h0000_0001);
        rd_words(2048);
        chk("output_ready_flag", output_ready_flag, 32'h0000_0000);
        $display("t_fill done");
    endtask : t_fill
    task automatic t_offset;
        wr_words(3);
        settle();
        write_data_in <= 18'h00005;
        @(posedge sys_clk);
        offset_capture_strobe_n <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (15) @(posedge sys_clk);
        chk("output_ready_flag", output_ready_flag, 32'h0000_0000);
        chk("input_ready_flag", input_ready_flag, 32'h0000_0000);
        chk("almost_boundary_flag", almost_boundary_flag, 32'h0000_0001);
        rst_b <= 1'b1;
        ticks(1'b0, 2);
        ahb(`DCF_REG_OFFSET, 1'b0, 32'h0000_0000);
        chk("offset", rdv, 32'h0000_0005);
        wr_words(6);
        settle();
        chk("almost_boundary_flag", almost_boundary_flag, 32'h0000_0001);
        wr_words(1);
        settle();
        chk("almost_boundary_flag", almost_boundary_flag, 32'h0000_0000);
        $display("t_offset done");
    endtask : t_offset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0; write_data_in = 18'h00000; write_enable_a = 1'b0; write_enable_b = 1'b0;
        offset_capture_strobe_n = 1'b1; read_enable_a = 1'b0; read_enable_b = 1'b0;
        output_enable = 1'b1; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0000_0000; rdv = 32'h0000_0000;
        repeat (16) @(posedge sys_clk);
        chk("half_full_flag", half_full_flag, 32'h0000_0000);
        chk("almost_boundary_flag", almost_boundary_flag, 32'h0000_0001);
        rst_b <= 1'b1;
        t_reset();
        t_first();
        t_refuse();
        t_fill();
        t_offset();
        results();
    end
endmodule : test_dcf_top
`default_nettype wire
